// ==== rtl/uart_reg_bank.sv ====
// Small storage bank of eight-bit registers with registered read data.
// Assumes writes and reads come from the map decoder on the same clock.
`include "uart_regmap_consts.svh"
module uart_reg_bank #(
	parameter int DEPTH = 8
) (
	input  wire logic                     clk,   // Clock
	input  wire logic                     arst_n, // Async reset
	input  wire logic                     ce,    // Clock enable
	input  wire logic                     we,    // Write strobe
	input  wire logic [$clog2(DEPTH)-1:0] waddr, // Write index
	input  wire logic [7:0]               wdata, // Write data
	input  wire logic [$clog2(DEPTH)-1:0] raddr, // Read index
	output logic      [7:0]               rdata  // Registered read data
);
	localparam int AW = $clog2(DEPTH);
	logic [7:0] mem_reg [DEPTH];
	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : g_ent
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n)
					mem_reg[g] <= `REG_RESET;
				else if (ce && we && waddr == AW'(g))
					mem_reg[g] <= wdata;
			end
		end
	endgenerate
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			rdata <= `REG_RESET;
		else if (ce)
			rdata <= mem_reg[raddr];
	end
endmodule

// ==== rtl/uart_regmap_consts.svh ====
// Constants for the register map and loopback block.
// Assumes inclusion by bare name from rtl/.
`ifndef UART_REGMAP_CONSTS_SVH
`define UART_REGMAP_CONSTS_SVH
`define LOC_DATA        3'h0
`define LOC_ONE         3'h1
`define LOC_TWO         3'h2
`define LOC_LINE_CTRL   3'h3
`define LOC_FOUR        3'h4
`define LOC_FIVE        3'h5
`define LOC_SIX         3'h6
`define LOC_SEVEN       3'h7
`define ENHANCED_KEY    8'hbf
`define DIV_ACCESS_BIT  7
`define LOOPBACK_BIT    4
`define DTR_BIT         0
`define RTS_BIT         1
`define ENH_ENABLE_BIT  4
`define FC_SELECT_BIT   6
`define SF_SELECT_BIT   0
`define REG_RESET       8'h00
`define LINE_CTRL_RESET 8'h03
`define BANK_COUNT      16
`endif

// ==== rtl/uart_regmap_loopback.sv ====
// Register map decode and internal loopback routing of a one-channel UART.
// Assumes the UART core supplies holding, status and level values on this clock;
// host strobes are one-cycle and synchronous to clk.
`include "uart_regmap_consts.svh"
module uart_regmap_loopback #(
	parameter logic [7:0] REVISION_CODE = 8'h01, // Arbitrary value
	parameter logic [7:0] IDENT_CODE    = 8'h5a  // Arbitrary value
) (
	input  wire logic                         clk,         // Clock, 250 MHz
	input  wire logic                         arst_n,      // Async reset
	input  wire logic                         ce,          // Clock enable
	input  wire uart_regmap_pkg::host_req_type req,        // Host access
	output logic      [7:0]                   rdata,       // Read data, registered
	input  wire logic [7:0]                   rhr_data,    // Receive holding byte
	input  wire logic [7:0]                   isr_data,    // Interrupt status
	input  wire logic [7:0]                   lsr_data,    // Line status
	input  wire logic [7:0]                   msr_data,    // Modem status
	input  wire logic [7:0]                   fc_data,     // FIFO level count
	output logic                              rhr_pop,     // Holding byte read
	output logic                              msr_read,    // Modem status read
	output logic                              thr_load,    // Transmit byte load
	output logic                              fcr_load,    // Queue control load
	output logic                              fifo_trigger_level_load,   // Trigger level load
	output logic                              enhanced_mode_select_load,   // Mode select load
	output logic      [7:0]                   wbyte,       // Write byte, registered
	output logic      [7:0]                   lcr_out,     // Line control value
	output logic      [7:0]                   mcr_out,     // Modem control value
	output logic                              loop_en,     // Loopback active
	input  wire logic                         tsr_out,     // Transmit shifter bit
	output logic                              rsr_in,      // Receive shifter bit
	output logic                              tx_pin,      // Serial out pin
	input  wire logic                         rx_pin,      // Serial in pin
	output logic                              rts_n,       // RTS output, low active
	output logic                              dtr_n,       // DTR output, low active
	input  wire uart_regmap_pkg::modem_in_type modem_pin,  // Modem input pins
	output uart_regmap_pkg::modem_in_type     modem_eff    // Modem inputs to core
);
	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	logic [7:0] lcr_reg, mcr_reg, ier_reg, dll_reg, dlm_reg, dld_reg;
	logic [7:0] efr_reg, feature_control_reg, sfr_reg, shr_reg, spr_reg;
	uart_regmap_pkg::wsel_type wsel;
	logic       key, dlab, enh, fsel, ssel, div_zero;
	logic       bank_we;
	logic [2:0] bank_waddr, bank_raddr;
	logic [7:0] bank_rdata;
	logic       rd_bank_reg;
	logic [7:0] rd_direct_reg;

	assign key      = lcr_reg == `ENHANCED_KEY;
	assign dlab     = lcr_reg[`DIV_ACCESS_BIT];
	assign enh      = efr_reg[`ENH_ENABLE_BIT];
	assign fsel     = feature_control_reg[`FC_SELECT_BIT];
	assign ssel     = sfr_reg[`SF_SELECT_BIT];
	assign div_zero = dll_reg == 8'h00 && dlm_reg == 8'h00;

	// ------------------------------------------------------------
	// Write decode
	// ------------------------------------------------------------
	always_comb begin
		wsel = uart_regmap_pkg::SEL_NONE;
		unique case (req.addr)
			`LOC_DATA:
				if (key)
					wsel = uart_regmap_pkg::SEL_NONE;
				else if (dlab)
					wsel = uart_regmap_pkg::SEL_DIV_LOW;
				else
					wsel = uart_regmap_pkg::SEL_HOLD;
			`LOC_ONE:
				if (key)
					wsel = uart_regmap_pkg::SEL_FEATURE_CONTROL;
				else if (dlab)
					wsel = uart_regmap_pkg::SEL_DIV_HIGH;
				else
					wsel = uart_regmap_pkg::SEL_IER;
			`LOC_TWO:
				if (key)
					wsel = uart_regmap_pkg::SEL_EFR;
				else if (dlab && enh)
					wsel = uart_regmap_pkg::SEL_DIV_FRAC;
				else
					wsel = uart_regmap_pkg::SEL_NONE;
			`LOC_LINE_CTRL:
				wsel = uart_regmap_pkg::SEL_LCR;
			`LOC_FOUR:
				wsel = key ? (ssel ? uart_regmap_pkg::SEL_PIN : uart_regmap_pkg::SEL_FLOW)
				           : uart_regmap_pkg::SEL_MCR;
			`LOC_FIVE:
				wsel = key ? (ssel ? uart_regmap_pkg::SEL_PIN : uart_regmap_pkg::SEL_FLOW)
				           : uart_regmap_pkg::SEL_SHR;
			`LOC_SIX:
				if (key)
					wsel = ssel ? uart_regmap_pkg::SEL_PIN : uart_regmap_pkg::SEL_FLOW;
				else if (enh)
					wsel = uart_regmap_pkg::SEL_SFR;
				else
					wsel = uart_regmap_pkg::SEL_NONE;
			`LOC_SEVEN:
				if (key)
					wsel = ssel ? uart_regmap_pkg::SEL_PIN : uart_regmap_pkg::SEL_FLOW;
				else if (fsel)
					wsel = uart_regmap_pkg::SEL_ENHANCED_MODE_SELECT;
				else if (!ssel)
					wsel = uart_regmap_pkg::SEL_SPR;
				else
					wsel = uart_regmap_pkg::SEL_NONE;
		endcase
	end

	// writes to read-only slots do nothing
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lcr_reg  <= `LINE_CTRL_RESET;
			mcr_reg  <= `REG_RESET;
			ier_reg  <= `REG_RESET;
			dll_reg  <= `REG_RESET;
			dlm_reg  <= `REG_RESET;
			dld_reg  <= `REG_RESET;
			efr_reg  <= `REG_RESET;
			feature_control_reg <= `REG_RESET;
			sfr_reg  <= `REG_RESET;
			shr_reg  <= `REG_RESET;
			spr_reg  <= `REG_RESET;
		end else if (ce && req.wr) begin
			unique case (wsel)
				uart_regmap_pkg::SEL_LCR:      lcr_reg  <= req.wdata;
				uart_regmap_pkg::SEL_MCR:      mcr_reg  <= req.wdata;
				uart_regmap_pkg::SEL_IER:      ier_reg  <= req.wdata;
				uart_regmap_pkg::SEL_DIV_LOW:  dll_reg  <= req.wdata;
				uart_regmap_pkg::SEL_DIV_HIGH: dlm_reg  <= req.wdata;
				uart_regmap_pkg::SEL_DIV_FRAC: dld_reg  <= req.wdata;
				uart_regmap_pkg::SEL_EFR:      efr_reg  <= req.wdata;
				uart_regmap_pkg::SEL_FEATURE_CONTROL:     feature_control_reg <= req.wdata;
				uart_regmap_pkg::SEL_SFR:      sfr_reg  <= req.wdata;
				uart_regmap_pkg::SEL_SHR:      shr_reg  <= req.wdata;
				uart_regmap_pkg::SEL_SPR:      spr_reg  <= req.wdata;
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Flow characters and pin registers
	// ------------------------------------------------------------
	// Index: bit 2 picks pin bank, low bits the slot within 4..7
	// flow characters at 4 to 7
	// pin registers at 4 to 7
	assign bank_we    = ce && req.wr && (wsel == uart_regmap_pkg::SEL_FLOW ||
	                                     wsel == uart_regmap_pkg::SEL_PIN);
	assign bank_waddr = {ssel, req.addr[1:0]};
	assign bank_raddr = {ssel, req.addr[1:0]};

	uart_reg_bank #(
		.DEPTH(8)
	) u_bank (
		.clk    (clk),
		.arst_n (arst_n),
		.ce     (ce),
		.we     (bank_we),
		.waddr  (bank_waddr),
		.wdata  (req.wdata),
		.raddr  (bank_raddr),
		.rdata  (bank_rdata)
	);

	// ------------------------------------------------------------
	// Read decode, one cycle latency
	// ------------------------------------------------------------
	logic       rd_use_bank;
	logic [7:0] rd_direct;
	always_comb begin
		rd_use_bank = 1'b0;
		rd_direct   = 8'h00;
		unique case (req.addr)
			`LOC_DATA:
				if (key)
					rd_direct = fc_data;
				else if (dlab)
					rd_direct = div_zero ? REVISION_CODE : dll_reg;
				else
					rd_direct = rhr_data;
			`LOC_ONE:
				if (key)
					rd_direct = feature_control_reg;
				else if (dlab)
					rd_direct = div_zero ? IDENT_CODE : dlm_reg;
				else
					rd_direct = ier_reg;
			`LOC_TWO:
				if (key)
					rd_direct = efr_reg;
				else if (dlab && enh)
					rd_direct = dld_reg;
				else
					rd_direct = isr_data;
			`LOC_LINE_CTRL:
				rd_direct = lcr_reg;
			`LOC_FOUR:
				if (key)
					rd_use_bank = 1'b1;
				else
					rd_direct = mcr_reg;
			`LOC_FIVE:
				if (key)
					rd_use_bank = 1'b1;
				else
					rd_direct = lsr_data;
			`LOC_SIX:
				if (key)
					rd_use_bank = 1'b1;
				else
					rd_direct = msr_data;
			`LOC_SEVEN:
				if (key)
					rd_use_bank = 1'b1;
				else if (fsel)
					rd_direct = fc_data;
				else if (!ssel)
					rd_direct = spr_reg;
				else
					rd_direct = 8'h00;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_bank_reg   <= 1'b0;
			rd_direct_reg <= 8'h00;
		end else if (ce && req.rd) begin
			rd_bank_reg   <= rd_use_bank;
			rd_direct_reg <= rd_direct;
		end
	end
	assign rdata = rd_bank_reg ? bank_rdata : rd_direct_reg;

	// ------------------------------------------------------------
	// Side-effect strobes to the core
	// ------------------------------------------------------------
	logic nokey_data, status2_rd;
	assign nokey_data = !key && !dlab && req.addr == `LOC_DATA;
	// status slot depends on enhanced enable
	assign status2_rd = req.addr == `LOC_TWO && (enh ? !dlab : !key);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rhr_pop   <= 1'b0;
			msr_read  <= 1'b0;
			thr_load  <= 1'b0;
			fcr_load  <= 1'b0;
			fifo_trigger_level_load <= 1'b0;
			enhanced_mode_select_load <= 1'b0;
			wbyte     <= 8'h00;
		end else if (ce) begin
			rhr_pop   <= req.rd && nokey_data;
			msr_read  <= req.rd && !key && req.addr == `LOC_SIX;
			thr_load  <= req.wr && nokey_data;
			fcr_load  <= req.wr && status2_rd;
			fifo_trigger_level_load <= req.wr && key && req.addr == `LOC_DATA;
			enhanced_mode_select_load <= req.wr && wsel == uart_regmap_pkg::SEL_ENHANCED_MODE_SELECT;
			if (req.wr)
				wbyte <= req.wdata;
		end
	end

	// ------------------------------------------------------------
	// Loopback routing
	// ------------------------------------------------------------
	logic [4:0] pins_sync;
	uart_sync2 #(
		.WIDTH(5),
		.INIT (5'h1f)
	) u_sync (
		.clk    (clk),
		.arst_n (arst_n),
		.ce     (ce),
		.d      ({rx_pin, modem_pin}),
		.q      (pins_sync)
	);

	assign loop_en = mcr_reg[`LOOPBACK_BIT];
	assign lcr_out = lcr_reg;
	assign mcr_out = mcr_reg;

	// core sees rerouted lines, and the mode change on loop_en and mcr_out
	// external receive level unused while looping
	assign rsr_in = loop_en ? tsr_out : pins_sync[4];

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_pin <= 1'b1;
			rts_n  <= 1'b1;
			dtr_n  <= 1'b1;
		end else if (ce) begin
			tx_pin <= loop_en ? 1'b1 : tsr_out;
			rts_n  <= loop_en ? 1'b1 : !mcr_reg[`RTS_BIT];
			dtr_n  <= loop_en ? 1'b1 : !mcr_reg[`DTR_BIT];
		end
	end

	// external modem inputs replaced: CTS and DSR by RTS and DTR, CD and RI held inactive
	always_comb begin
		if (loop_en) begin
			modem_eff.cts_n = !mcr_reg[`RTS_BIT];
			modem_eff.dsr_n = !mcr_reg[`DTR_BIT];
			modem_eff.cd_n  = 1'b1;
			modem_eff.ri_n  = 1'b1;
		end else begin
			modem_eff = pins_sync[3:0];
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_tx_mark_loop: assert property (@(posedge clk) disable iff (!arst_n)
		ce && loop_en |=> tx_pin) else $error("tx pin not high in loopback");
	a_rts_dtr_off: assert property (@(posedge clk) disable iff (!arst_n)
		ce && loop_en |=> rts_n && dtr_n) else $error("modem outputs asserted in loopback");
	a_loop_route: assert property (@(posedge clk) disable iff (!arst_n)
		loop_en |-> rsr_in == tsr_out) else $error("receive shifter not fed from transmit");
	a_modem_ignore: assert property (@(posedge clk) disable iff (!arst_n)
		loop_en |-> modem_eff.cd_n && modem_eff.ri_n) else $error("modem inputs not isolated");
	a_lcr_write: assert property (@(posedge clk) disable iff (!arst_n)
		ce && req.wr && req.addr == `LOC_LINE_CTRL |=> lcr_reg == $past(req.wdata))
		else $error("line control write lost");
	a_loop_enter: assert property (@(posedge clk) disable iff (!arst_n)
		ce && req.wr && !key && req.addr == `LOC_FOUR && req.wdata[`LOOPBACK_BIT]
		|=> loop_en) else $error("loopback not entered");
	a_thr_load: assert property (@(posedge clk) disable iff (!arst_n)
		ce && req.wr && !dlab && req.addr == `LOC_DATA |=> thr_load)
		else $error("transmit holding not loaded");
	a_rev_read: assert property (@(posedge clk) disable iff (!arst_n)
		ce && req.rd && dlab && !key && div_zero && req.addr == `LOC_DATA
		|=> rdata == REVISION_CODE) else $error("revision not returned");
	a_ro_ignore: assert property (@(posedge clk) disable iff (!arst_n)
		ce && req.wr && !key && !enh && req.addr == `LOC_SIX |=> $stable(sfr_reg))
		else $error("special function written without enable");
endmodule

// ==== rtl/uart_regmap_pkg.sv ====
// Types shared by the register map block.
// Assumes the consts header is available.
package uart_regmap_pkg;
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [2:0] addr;
		logic [7:0] wdata;
	} host_req_type;
	typedef struct packed {
		logic cts_n;
		logic dsr_n;
		logic cd_n;
		logic ri_n;
	} modem_in_type;
	typedef enum logic [3:0] {
		SEL_NONE, SEL_DIV_LOW, SEL_DIV_HIGH, SEL_DIV_FRAC, SEL_IER, SEL_LCR, SEL_MCR,
		SEL_SHR, SEL_SFR, SEL_SPR, SEL_ENHANCED_MODE_SELECT, SEL_FEATURE_CONTROL, SEL_EFR, SEL_FLOW, SEL_PIN,
		SEL_HOLD
	} wsel_type;
endpackage

// ==== rtl/uart_sync2.sv ====
// Two-flop synchroniser for a group of pin inputs.
// Assumes inputs are asynchronous to clk.
module uart_sync2 #(
	parameter int WIDTH = 5,
	parameter logic [WIDTH-1:0] INIT = '1
) (
	input  wire logic             clk,    // Clock
	input  wire logic             arst_n, // Async reset
	input  wire logic             ce,     // Clock enable
	input  wire logic [WIDTH-1:0] d,      // Async input
	output logic      [WIDTH-1:0] q       // Synchronised
);
	logic [WIDTH-1:0] meta_reg;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_reg <= INIT;
			q        <= INIT;
		end else if (ce) begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule

// ==== tb/host_model.sv ====
// Host processor model for the eight-location register bus.
// Assumes one-cycle rd/wr strobes taken on posedge clk, read data valid after.
module host_model (
	input  wire logic                          clk,   // Clock
	input  wire logic [7:0]                    rdata, // Read data from block
	output uart_regmap_pkg::host_req_type      req    // Access to block
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// Bus cycles
	// ----------------------------------------
	initial req = '0;

	// Released lines show the inverse, so a stale value cannot pass by luck
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(negedge clk);
		req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		@(negedge clk);
		req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
		@(negedge clk);
	endtask

	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(negedge clk);
		req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		@(negedge clk);
		// Bank data follows the index, so take it before the index moves
		d = rdata;
		req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hff};
		@(negedge clk);
	endtask
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the register map and loopback block.
// Assumes the host model drives req; core values are fixed constants.
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
	$display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	localparam logic [7:0] REV_V  = 8'h2b; // Arbitrary value
	localparam logic [7:0] ID_V   = 8'hd4; // Arbitrary value
	localparam logic [7:0] HOLD_V = 8'h3c;
	localparam logic [7:0] IRQ_V  = 8'hc1;
	localparam logic [7:0] LST_V  = 8'h60;
	localparam logic [7:0] MST_V  = 8'hb0;
	localparam logic [7:0] LVL_V  = 8'h07;
	logic                          clk, arst_n, ce, tsr_out, rx_pin;
	uart_regmap_pkg::host_req_type req;
	uart_regmap_pkg::modem_in_type modem_pin, modem_eff;
	logic [7:0]                    rdata, wbyte, lcr_out, mcr_out;
	logic                          rhr_pop, msr_read, thr_load, fcr_load, fifo_trigger_level_load, enhanced_mode_select_load;
	logic                          loop_en, rsr_in, tx_pin, rts_n, dtr_n;
	logic [5:0]                    seen;
	int                            n_mismatch, cmp_count;

	host_model host (.clk(clk), .rdata(rdata), .req(req));
	uart_regmap_loopback #(.REVISION_CODE(REV_V), .IDENT_CODE(ID_V)) u_uart_regmap_loopback (
		.clk(clk), .arst_n(arst_n), .ce(ce), .req(req), .rdata(rdata),
		.rhr_data(HOLD_V), .isr_data(IRQ_V), .lsr_data(LST_V), .msr_data(MST_V),
		.fc_data(LVL_V), .rhr_pop(rhr_pop), .msr_read(msr_read), .thr_load(thr_load),
		.fcr_load(fcr_load), .fifo_trigger_level_load(fifo_trigger_level_load), .enhanced_mode_select_load(enhanced_mode_select_load), .wbyte(wbyte),
		.lcr_out(lcr_out), .mcr_out(mcr_out), .loop_en(loop_en), .tsr_out(tsr_out),
		.rsr_in(rsr_in), .tx_pin(tx_pin), .rx_pin(rx_pin), .rts_n(rts_n), .dtr_n(dtr_n),
		.modem_pin(modem_pin), .modem_eff(modem_eff));

	// Sticky capture, so pulse timing within the access does not matter
	always @(posedge clk) begin
		seen <= seen | {rhr_pop, msr_read, thr_load, fcr_load, fifo_trigger_level_load, enhanced_mode_select_load};
	end

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic rchk(input string nm, input logic [2:0] a, input logic [7:0] e);
		logic [7:0] d;
		host.rd(a, d);
		`CHK(nm, e, d)
	endtask

	task automatic pchk(input string nm, input logic [5:0] e);
		`CHK(nm, e, seen)
		seen = '0;
	endtask

	task stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_reset;
		`CHK("lcr_out", 8'h03, lcr_out)
		`CHK("mcr_out", 8'h00, mcr_out)
		`CHK("loop_en", 1'b0, loop_en)
		rchk("lcr rd", 3'h3, 8'h03);
	endtask

	task t_normal;
		host.wr(3'h1, 8'ha5);
		rchk("ier", 3'h1, 8'ha5);
		host.wr(3'h4, 8'h03);
		`CHK("rts dtr on", 2'b00, {rts_n, dtr_n})
		rchk("hold", 3'h0, HOLD_V);
		pchk("pop", 6'h20);
		host.wr(3'h0, 8'h5e);
		pchk("tx load", 6'h08);
		`CHK("wbyte", 8'h5e, wbyte)
		rchk("istat", 3'h2, IRQ_V);
		host.wr(3'h2, 8'hc7);
		pchk("queue ctl", 6'h04);
		host.wr(3'h5, 8'h11);
		rchk("lstat", 3'h5, LST_V);
		rchk("mstat", 3'h6, MST_V);
		pchk("mstat read", 6'h10);
		host.wr(3'h7, 8'h69);
		rchk("scratch", 3'h7, 8'h69);
		ce = 1'b0;
		host.wr(3'h7, 8'h96);
		ce = 1'b1;
		rchk("ce frozen", 3'h7, 8'h69);
	endtask

	task t_divisor;
		host.wr(3'h3, 8'h80);
		rchk("revision", 3'h0, REV_V);
		rchk("ident", 3'h1, ID_V);
		host.wr(3'h0, 8'h12);
		rchk("div low", 3'h0, 8'h12);
		rchk("div high", 3'h1, 8'h00);
		host.wr(3'h1, 8'h34);
		rchk("div high wr", 3'h1, 8'h34);
		rchk("istat no enh", 3'h2, IRQ_V);
		host.wr(3'h3, 8'h03);
		rchk("ier kept", 3'h1, 8'ha5);
	endtask

	task t_enhanced;
		host.wr(3'h3, 8'hbf);
		rchk("level", 3'h0, LVL_V);
		host.wr(3'h0, 8'h44);
		pchk("fifo_trigger_level", 6'h02);
		host.wr(3'h1, 8'h40);
		rchk("feature", 3'h1, 8'h40);
		host.wr(3'h2, 8'h10);
		rchk("enh fn", 3'h2, 8'h10);
		rchk("key", 3'h3, 8'hbf);
		for (int i = 4; i < 8; i++) host.wr(3'(i), 8'(8'ha0 + i));
		for (int i = 4; i < 8; i++) rchk("flow", 3'(i), 8'(8'ha0 + i));
		host.wr(3'h3, 8'h03);
		rchk("mcr kept", 3'h4, 8'h03);
		rchk("level7", 3'h7, LVL_V);
		host.wr(3'h7, 8'h3a);
		pchk("mode sel", 6'h01);
		host.wr(3'h6, 8'h01);
		host.wr(3'h3, 8'hbf);
		for (int i = 4; i < 8; i++) host.wr(3'(i), 8'(8'hc0 + i));
		for (int i = 4; i < 8; i++) rchk("pin reg", 3'(i), 8'(8'hc0 + i));
		host.wr(3'h3, 8'h03);
		host.wr(3'h6, 8'h00);
		host.wr(3'h3, 8'hbf);
		for (int i = 4; i < 8; i++) rchk("flow kept", 3'(i), 8'(8'ha0 + i));
		host.wr(3'h3, 8'h80);
		host.wr(3'h2, 8'h0c);
		rchk("fraction", 3'h2, 8'h0c);
		host.wr(3'h3, 8'h03);
	endtask

	task t_loop;
		// Far side keeps the receive line at mark throughout
		rx_pin = 1'b1;
		host.wr(3'h4, 8'h13);
		modem_pin = '0;
		tsr_out = 1'b0;
		repeat (3) @(negedge clk);
		`CHK("loop on", 1'b1, loop_en)
		`CHK("tx mark", 1'b1, tx_pin)
		`CHK("rts dtr off", 2'b11, {rts_n, dtr_n})
		`CHK("modem eff", 4'b0011, modem_eff)
		`CHK("rsr low", 1'b0, rsr_in)
		@(negedge clk);
		tsr_out = 1'b1;
		#1;
		`CHK("rsr high", 1'b1, rsr_in)
		rchk("lstat loop", 3'h5, LST_V);
		host.wr(3'h4, 8'h03);
		repeat (3) @(negedge clk);
		`CHK("loop off", 1'b0, loop_en)
		`CHK("rts dtr back", 2'b00, {rts_n, dtr_n})
		`CHK("pins back", 4'b0000, modem_eff)
		`CHK("rx back", 1'b1, rsr_in)
		tsr_out = 1'b0;
		repeat (2) @(negedge clk);
		`CHK("tx follows", 1'b0, tx_pin)
		tsr_out = 1'b1;
	endtask

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		arst_n = 1'b0;
		ce = 1'b1;
		tsr_out = 1'b1;
		rx_pin = 1'b1;
		modem_pin = '1;
		seen = '0;
		n_mismatch = 0;
		cmp_count = 0;
		repeat (16) @(negedge clk);
		arst_n = 1'b1;
		@(negedge clk);
		seen = '0;
		t_reset;
		t_normal;
		t_divisor;
		t_enhanced;
		t_loop;
		stop_test;
	end

	// About 70 accesses of three cycles each; a wide margin on top
	initial begin
		#200000;
		n_mismatch++;
		stop_test;
	end
endmodule
